// *** include/scr_pkg.sv ***
// constants for the switch global control register block
//
// Overview of operation
// - bit 7 low: 32 streams, per-stream rates
// - bit 7 high: streams 0-15 at 32 Mb/s
// - bit 5 inverts both output clocks
// - bit 4 arms connection memory block programming
// - outputs enabled only if pin and bit 3 high
// - standby: data idle per strap, driver controls low
// - bits 2-0 route host memory accesses
// - data memories read-only, connection memories read-write
// - clearing arm bit aborts running block programming
package scr_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int          ADDR_W            = 15;      // host address width
  localparam int          DATA_W            = 16;      // host data width
  localparam logic [14:0] GLOBAL_CONTROL_OFS = 15'h0000; // control register
  localparam logic [15:0] GLOBAL_CONTROL_RST = 16'h0000; // reset value
  localparam logic [15:0] GLOBAL_CONTROL_MSK = 16'h01ff; // bits 15-9 reserved

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int FPW_BIT     = 8; // frame pulse width select
  localparam int HRATE_BIT   = 7; // backplane high rate mode
  localparam int ALIGN_BIT   = 6; // input clock align polarity
  localparam int CKINV_BIT   = 5; // output clock invert
  localparam int ARM_BIT     = 4; // block program arm
  localparam int STBY_BIT    = 3; // output standby
  localparam int MSEL_LSB    = 0; // memory select low bit
  localparam int MSEL_W      = 3; // memory select width

  // ----------------------------------------------------------------
  // memory select codes
  // ----------------------------------------------------------------
  localparam logic [2:0] MSEL_LCM = 3'h0; // local connection memory
  localparam logic [2:0] MSEL_BCM = 3'h1; // backplane connection memory
  localparam logic [2:0] MSEL_LDM = 3'h2; // local data memory
  localparam logic [2:0] MSEL_BDM = 3'h3; // backplane data memory

  // ----------------------------------------------------------------
  // stream counts
  // ----------------------------------------------------------------
  localparam int BP_STREAMS     = 32; // backplane streams, normal mode
  localparam int BP_STREAMS_HI  = 16; // backplane streams at 32 Mb/s
  localparam int LOC_STREAMS    = 16; // local streams
  localparam int BP_DRV_CTRL    = 4;  // backplane driver controls
  localparam int LOC_DRV_CTRL   = 2;  // local driver controls

endpackage : scr_pkg

// *** rtl/scr_mem_router.sv ***
// routes host memory accesses by the memory select field
`timescale 1ns/100ps
module scr_mem_router #(
  parameter int MEM_AW = 13, // memory word address width
  parameter int MEM_DW = 16  // memory word width
) (
  input  wire logic [2:0]        memory_select,
  input  wire logic              mem_wr,
  input  wire logic              mem_rd,
  input  wire logic [MEM_AW-1:0] mem_addr,
  input  wire logic [MEM_DW-1:0] mem_wdata,
  output logic      [MEM_DW-1:0] mem_rdata,
  output logic                   lcm_wr,
  output logic                   lcm_rd,
  output logic                   bcm_wr,
  output logic                   bcm_rd,
  output logic                   ldm_rd,
  output logic                   bdm_rd,
  output logic      [MEM_AW-1:0] sel_addr,
  output logic      [MEM_DW-1:0] sel_wdata,
  input  wire logic [MEM_DW-1:0] lcm_rdata,
  input  wire logic [MEM_DW-1:0] bcm_rdata,
  input  wire logic [MEM_DW-1:0] ldm_rdata,
  input  wire logic [MEM_DW-1:0] bdm_rdata,
  input  wire logic              ref_clk,
  input  wire logic              rstn
);

  initial begin
    if (MEM_AW < 1 || MEM_DW < 1) $error("scr_mem_router: bad widths");
  end

  logic [2:0] rd_sel; // select held for the read answer cycle

  // ----------------------------------------------------------------
  // strobe steering
  // ----------------------------------------------------------------
  // connection memories take reads and writes
  assign lcm_wr    = mem_wr && (memory_select == scr_pkg::MSEL_LCM);
  assign bcm_wr    = mem_wr && (memory_select == scr_pkg::MSEL_BCM);
  assign lcm_rd    = mem_rd && (memory_select == scr_pkg::MSEL_LCM);
  assign bcm_rd    = mem_rd && (memory_select == scr_pkg::MSEL_BCM);
  // data memories get no write strobe at all, so they stay read-only
  assign ldm_rd    = mem_rd && (memory_select == scr_pkg::MSEL_LDM);
  assign bdm_rd    = mem_rd && (memory_select == scr_pkg::MSEL_BDM);
  assign sel_addr  = mem_addr;
  assign sel_wdata = mem_wdata;

  // remember which memory answers next cycle
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rd_sel <= 3'h7;
    end else if (mem_rd) begin
      rd_sel <= memory_select;
    end
  end

  // read mux; undefined codes answer zero
  always_comb begin
    unique case (rd_sel)
      scr_pkg::MSEL_LCM: mem_rdata = lcm_rdata;
      scr_pkg::MSEL_BCM: mem_rdata = bcm_rdata;
      scr_pkg::MSEL_LDM: mem_rdata = ldm_rdata;
      scr_pkg::MSEL_BDM: mem_rdata = bdm_rdata;
      default:           mem_rdata = '0;
    endcase
  end

endmodule : scr_mem_router

// *** rtl/scr_global_control.sv ***
// global control register of the time-slot switch and its effects
`timescale 1ns/100ps
module scr_global_control #(
  parameter int MEM_AW = 13, // memory word address width
  parameter int MEM_DW = 16  // memory word width
) (
  input  wire logic                  ref_clk,
  input  wire logic                  rstn,
  // register port
  input  wire logic [14:0]           reg_addr,
  input  wire logic [15:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [15:0]           reg_rdata,
  // host memory port
  input  wire logic                  mem_wr,
  input  wire logic                  mem_rd,
  input  wire logic [MEM_AW-1:0]     mem_addr,
  input  wire logic [MEM_DW-1:0]     mem_wdata,
  output logic      [MEM_DW-1:0]     mem_rdata,
  output logic                       lcm_wr,
  output logic                       lcm_rd,
  output logic                       bcm_wr,
  output logic                       bcm_rd,
  output logic                       ldm_rd,
  output logic                       bdm_rd,
  output logic      [MEM_AW-1:0]     sel_addr,
  output logic      [MEM_DW-1:0]     sel_wdata,
  input  wire logic [MEM_DW-1:0]     lcm_rdata,
  input  wire logic [MEM_DW-1:0]     bcm_rdata,
  input  wire logic [MEM_DW-1:0]     ldm_rdata,
  input  wire logic [MEM_DW-1:0]     bdm_rdata,
  // block programming handshake
  input  wire logic                  block_program_go,
  output logic                       block_program_abort,
  output logic                       block_program_enable,
  // clock and pin controls
  input  wire logic                  clock_in_8m,
  output logic                       clock_out_8m,
  input  wire logic                  clock_in_16m,
  output logic                       clock_out_16m,
  output logic                       frame_pulse_width_sel,
  output logic                       input_clock_align_polarity,
  output logic                       backplane_high_rate_mode,
  output logic [31:0]                backplane_stream_active,
  output logic                       per_stream_rate_enable,
  input  wire logic                  output_disable_pin,
  input  wire logic                  backplane_idle_state_pin,
  input  wire logic                  local_idle_state_pin,
  // serial data from the switching core
  input  wire logic [31:0]           backplane_core_out,
  input  wire logic [15:0]           local_core_out,
  input  wire logic [3:0]            backplane_core_ctrl,
  input  wire logic [1:0]            local_core_ctrl,
  // serial outputs, each as value plus enable; driver controls as value only
  output logic [31:0]                backplane_serial_out,
  output logic [31:0]                backplane_serial_out_oe,
  output logic [15:0]                local_serial_out,
  output logic [15:0]                local_serial_out_oe,
  output logic [3:0]                 backplane_driver_ctrl_out,
  output logic [1:0]                 local_driver_ctrl_out
);

  initial begin
    if (MEM_AW < 1 || MEM_DW < 1) $error("scr_global_control: bad widths");
  end

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  logic [15:0] global_control; // live control word
  logic        arm_q;          // arm bit one cycle ago
  logic        outputs_on;     // combined output enable
  logic        ctl_hit;        // address decodes to the control register

  assign ctl_hit = (reg_addr == scr_pkg::GLOBAL_CONTROL_OFS);

  // software write; reserved bits are never stored
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      global_control <= scr_pkg::GLOBAL_CONTROL_RST;
    end else if (reg_wr && ctl_hit) begin
      global_control <= reg_wdata & scr_pkg::GLOBAL_CONTROL_MSK;
    end
  end

  // read answer one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd && ctl_hit) begin
      reg_rdata <= global_control;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // field decode
  // ----------------------------------------------------------------
  // width is only advertised; the frame source must match it
  assign frame_pulse_width_sel      = global_control[scr_pkg::FPW_BIT];
  // alignment needs host to set this high; hardware only passes it on
  assign input_clock_align_polarity = global_control[scr_pkg::ALIGN_BIT];
  assign backplane_high_rate_mode   = global_control[scr_pkg::HRATE_BIT];
  // per-stream rate programming only when not in high rate mode
  assign per_stream_rate_enable     = ~backplane_high_rate_mode;

  // which backplane streams run: all 32, or 0-15 at 32 Mb/s
  always_comb begin
    for (int i = 0; i < scr_pkg::BP_STREAMS; i++) begin
      backplane_stream_active[i] = per_stream_rate_enable ||
                                   (i < scr_pkg::BP_STREAMS_HI);
    end
  end

  // output clocks follow the input or are inverted together
  assign clock_out_8m  = clock_in_8m  ^ global_control[scr_pkg::CKINV_BIT];
  assign clock_out_16m = clock_in_16m ^ global_control[scr_pkg::CKINV_BIT];

  // ----------------------------------------------------------------
  // block programming arm and abort
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      arm_q <= 1'b0;
    end else begin
      arm_q <= global_control[scr_pkg::ARM_BIT];
    end
  end

  // the engine may only run while armed
  assign block_program_enable = global_control[scr_pkg::ARM_BIT] & block_program_go;
  // falling arm bit during a run is a one-cycle abort pulse
  assign block_program_abort  = arm_q & ~global_control[scr_pkg::ARM_BIT]
                                & block_program_go;

  // ----------------------------------------------------------------
  // output enable and standby
  // ----------------------------------------------------------------
  // pin low wins over the bit
  assign outputs_on = output_disable_pin & global_control[scr_pkg::STBY_BIT];

  // standby drives idle high when strapped, else floats; the
  // driver controls go low so external buffers stay off
  always_comb begin
    for (int i = 0; i < scr_pkg::BP_STREAMS; i++) begin
      backplane_serial_out[i]    = outputs_on ? backplane_core_out[i] : 1'b1;
      backplane_serial_out_oe[i] = (outputs_on && backplane_stream_active[i]) ||
                                   (!outputs_on && backplane_idle_state_pin);
    end
    for (int j = 0; j < scr_pkg::LOC_STREAMS; j++) begin
      local_serial_out[j]    = outputs_on ? local_core_out[j] : 1'b1;
      local_serial_out_oe[j] = outputs_on || local_idle_state_pin;
    end
    backplane_driver_ctrl_out = outputs_on ? backplane_core_ctrl : 4'h0;
    local_driver_ctrl_out     = outputs_on ? local_core_ctrl : 2'h0;
  end

  // ----------------------------------------------------------------
  // host memory routing
  // ----------------------------------------------------------------
  scr_mem_router #(
    .MEM_AW (MEM_AW),
    .MEM_DW (MEM_DW)
  ) u_router (
    .memory_select (global_control[scr_pkg::MSEL_LSB +: scr_pkg::MSEL_W]),
    .mem_wr        (mem_wr),
    .mem_rd        (mem_rd),
    .mem_addr      (mem_addr),
    .mem_wdata     (mem_wdata),
    .mem_rdata     (mem_rdata),
    .lcm_wr        (lcm_wr),
    .lcm_rd        (lcm_rd),
    .bcm_wr        (bcm_wr),
    .bcm_rd        (bcm_rd),
    .ldm_rd        (ldm_rd),
    .bdm_rd        (bdm_rd),
    .sel_addr      (sel_addr),
    .sel_wdata     (sel_wdata),
    .lcm_rdata     (lcm_rdata),
    .bcm_rdata     (bcm_rdata),
    .ldm_rdata     (ldm_rdata),
    .bdm_rdata     (bdm_rdata),
    .ref_clk       (ref_clk),
    .rstn          (rstn)
  );

endmodule : scr_global_control

// *** dv/scr_gc_asserts.sv ***
// concurrent checks on the global control register block
`timescale 1ns/100ps
module scr_gc_asserts #(
  parameter int MEM_AW = 13, // memory word address width
  parameter int MEM_DW = 16  // memory word width
) (
  input wire logic              ref_clk, rstn, reg_wr, reg_rd, mem_wr, mem_rd,
  input wire logic [14:0]       reg_addr,
  input wire logic [15:0]       reg_wdata, reg_rdata, local_core_out, local_serial_out,
  input wire logic [15:0]       local_serial_out_oe,
  input wire logic [MEM_DW-1:0] mem_rdata,
  input wire logic              lcm_wr, lcm_rd, bcm_wr, bcm_rd, ldm_rd, bdm_rd,
  input wire logic              block_program_go, block_program_abort, block_program_enable,
  input wire logic              clock_in_8m, clock_out_8m, clock_in_16m, clock_out_16m,
  input wire logic              frame_pulse_width_sel, backplane_high_rate_mode,
  input wire logic              per_stream_rate_enable, output_disable_pin,
  input wire logic              backplane_idle_state_pin, local_idle_state_pin,
  input wire logic [31:0]       backplane_stream_active, backplane_serial_out_oe,
  input wire logic [3:0]        backplane_core_ctrl, backplane_driver_ctrl_out,
  input wire logic [1:0]        local_core_ctrl, local_driver_ctrl_out
);
  // ----------------------------------------------------------------
  // shadow of the control word, rebuilt from the register port
  // ----------------------------------------------------------------
  logic [15:0] sh; // reserved bits never stored
  logic        on; // serial outputs live
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) sh <= 16'h0000;
    else if (reg_wr && reg_addr == 15'h0000) sh <= reg_wdata & 16'h01ff;
  end
  assign on = output_disable_pin & sh[3];
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence s_rd; reg_rd && reg_addr == 15'h0000; endsequence
  sequence s_disarm; reg_wr && reg_addr == 15'h0000 && sh[4] && !reg_wdata[4]; endsequence
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_RDATA: assert property (s_rd |=> reg_rdata == $past(sh))
    else $error("control word readback wrong");
  AST_RDZERO: assert property (!(reg_rd && reg_addr == 15'h0000) |=> reg_rdata == 16'h0000)
    else $error("read data not zero outside a read");
  AST_FPW: assert property (frame_pulse_width_sel == sh[8])
    else $error("frame pulse width select wrong");
  AST_RATE: assert property (per_stream_rate_enable == !sh[7])
    else $error("per stream rate enable wrong");
  AST_ACTIVE: assert property (backplane_stream_active ==
    (sh[7] ? 32'h0000ffff : 32'hffffffff)) else $error("active stream set wrong");
  AST_CKINV: assert property (clock_out_8m == (clock_in_8m ^ sh[5]) &&
    clock_out_16m == (clock_in_16m ^ sh[5])) else $error("output clock polarity wrong");
  AST_ARM: assert property (block_program_enable == (sh[4] & block_program_go))
    else $error("block program enable wrong");
  AST_ABORT: assert property (s_disarm ##1 block_program_go |-> block_program_abort)
    else $error("abort missing after disarm");
  AST_ON: assert property (on |-> local_serial_out == local_core_out &&
    &local_serial_out_oe && backplane_driver_ctrl_out == backplane_core_ctrl)
    else $error("enabled outputs wrong");
  AST_STBY: assert property (!on |-> local_driver_ctrl_out == 2'h0 &&
    backplane_serial_out_oe == {32{backplane_idle_state_pin}} &&
    local_serial_out_oe == {16{local_idle_state_pin}}) else $error("standby outputs wrong");
  AST_ROUTE: assert property (mem_rd |-> {lcm_rd, bcm_rd, ldm_rd, bdm_rd} ==
    (sh[2] ? 4'h0 : 4'h8 >> sh[1:0])) else $error("read strobe routing wrong");
  AST_WRSEL: assert property (mem_wr |-> {lcm_wr, bcm_wr} ==
    (sh[2:1] == 2'h0 ? 2'h2 >> sh[0] : 2'h0)) else $error("write strobe routing wrong");
  AST_UNDEF: assert property (mem_rd && sh[2] |=> mem_rdata == '0)
    else $error("undefined select read not zero");
endmodule : scr_gc_asserts

bind scr_global_control scr_gc_asserts #(.MEM_AW(MEM_AW), .MEM_DW(MEM_DW)) scr_gc_asserts_inst (.*);

// *** dv/scr_mem_model.sv ***
// four switch memories answering host reads
`timescale 1ns/100ps
module scr_mem_model #(
  parameter int MEM_AW = 13 // memory word address width
) (
  input wire logic              ref_clk, lcm_rd, bcm_rd, ldm_rd, bdm_rd,
  input wire logic [MEM_AW-1:0] sel_addr,
  output logic     [15:0]       lcm_rdata, bcm_rdata, ldm_rdata, bdm_rdata
);
  logic [15:0] a; // address as a data word
  assign a = 16'(sel_addr);
  // answer one cycle after the strobe; otherwise flip the bus so stale data never matches
  // data memories have no write port at all
  always_ff @(posedge ref_clk) begin
    lcm_rdata <= lcm_rd ? a : ~lcm_rdata;
    bcm_rdata <= bcm_rd ? a ^ 16'h2000 : ~bcm_rdata;
    ldm_rdata <= ldm_rd ? a ^ 16'h4000 : ~ldm_rdata;
    bdm_rdata <= bdm_rd ? a ^ 16'h6000 : ~bdm_rdata;
  end
endmodule : scr_mem_model

// *** dv/tb_top.sv ***
// self-checking bench for the global control register block
`timescale 1ns/100ps
module tb_top;
  logic        ref_clk, rstn, reg_wr, reg_rd, mem_wr, mem_rd, block_program_go, on;
  logic        clock_in_8m, clock_in_16m, clock_out_8m, clock_out_16m, block_program_abort;
  logic        output_disable_pin, backplane_idle_state_pin, local_idle_state_pin;
  logic        block_program_enable, frame_pulse_width_sel, input_clock_align_polarity;
  logic        backplane_high_rate_mode, per_stream_rate_enable;
  logic        lcm_wr, lcm_rd, bcm_wr, bcm_rd, ldm_rd, bdm_rd;
  logic [14:0] reg_addr;
  logic [12:0] mem_addr, sel_addr;
  logic [15:0] reg_wdata, reg_rdata, q, mem_wdata, mem_rdata, sel_wdata, lcm_rdata, bcm_rdata;
  logic [15:0] ldm_rdata, bdm_rdata, local_core_out, local_serial_out, local_serial_out_oe;
  logic [31:0] backplane_core_out, backplane_serial_out, backplane_serial_out_oe;
  logic [31:0] backplane_stream_active;
  logic [3:0]  backplane_core_ctrl, backplane_driver_ctrl_out;
  logic [1:0]  local_core_ctrl, local_driver_ctrl_out;
  int          mismatches, tests_run, seed;
  int          mdl; // model of the control word
  scr_global_control scr_global_control_inst (.*);
  scr_mem_model      scr_mem_model_inst (.*);
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // ----------------------------------------------------------------
  // compares, bus cycles, verdict
  // ----------------------------------------------------------------
  task automatic cmp_reg(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %0t register got %h want %h", $time, got, exp);
    end
  endtask : cmp_reg
  task automatic cmp_pin(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %0t pin got %h want %h", $time, got, exp);
    end
  endtask : cmp_pin
  task automatic wr(input logic [14:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    if (a == 15'h0000) mdl = d & 16'h01ff; // reserved bits drop
    #1;
  endtask : wr
  task automatic rd(input logic [14:0] a);
    @(posedge ref_clk);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 q = reg_rdata; // data stand only in this cycle
  endtask : rd
  task automatic chk_fields;
    cmp_pin(frame_pulse_width_sel, mdl[8]);
    cmp_pin(per_stream_rate_enable, !mdl[7]);
    cmp_pin(backplane_high_rate_mode, mdl[7]);
    cmp_pin(backplane_stream_active, mdl[7] ? 32'h0000ffff : 32'hffffffff);
    cmp_pin(input_clock_align_polarity, mdl[6]);
    cmp_pin({clock_out_16m, clock_out_8m}, {clock_in_16m, clock_in_8m} ^ {2{mdl[5]}});
    cmp_pin(block_program_enable, mdl[4] & block_program_go);
  endtask : chk_fields
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  // watchdog: the whole run needs well under 1000 cycles
  initial begin
    #100000;
    mismatches++;
    tally_and_finish;
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {rstn, reg_wr, reg_rd, mem_wr, mem_rd, block_program_go, clock_in_8m, clock_in_16m} = 8'h00;
    {output_disable_pin, backplane_idle_state_pin, local_idle_state_pin} = 3'h0;
    {reg_addr, reg_wdata, mem_addr, mem_wdata} = '0;
    {backplane_core_out, local_core_out, backplane_core_ctrl, local_core_ctrl} = '0;
    seed = 51; mismatches = 0; tests_run = 0; mdl = 0;
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    rd(15'h0000); cmp_reg(q, 16'h0000);
    chk_fields;
    wr(15'h0000, 16'hffff); rd(15'h0000); cmp_reg(q, 16'h01ff);
    wr(15'h0001, 16'h0000); rd(15'h0001); cmp_reg(q, 16'h0000);
    rd(15'h0000); cmp_reg(q, mdl[15:0]);
    $display("test reset_and_map done");
    for (int i = 0; i < 12; i++) begin
      @(posedge ref_clk);
      clock_in_8m <= $random(seed); clock_in_16m <= $random(seed); block_program_go <= $random(seed);
      wr(15'h0000, 16'($random(seed)));
      chk_fields;
      rd(15'h0000); cmp_reg(q, mdl[15:0]);
    end
    $display("test random_fields done");
    for (int i = 0; i < 32; i++) begin
      wr(15'h0000, {8'h00, i[4], 3'h0, i[0], 3'h0});
      {output_disable_pin, backplane_idle_state_pin, local_idle_state_pin} <= i[3:1];
      backplane_core_out <= $random(seed); local_core_out <= $random(seed);
      {backplane_core_ctrl, local_core_ctrl} <= $random(seed);
      @(posedge ref_clk);
      #1 on = i[0] & i[3];
      cmp_pin(local_serial_out_oe, on ? 16'hffff : {16{i[1]}});
      cmp_pin(backplane_serial_out_oe,
        on ? (i[4] ? 32'h0000ffff : 32'hffffffff) : {32{i[2]}});
      cmp_pin({backplane_serial_out[15:0], local_serial_out},
        on ? {backplane_core_out[15:0], local_core_out} : 32'hffffffff);
      cmp_pin(backplane_serial_out[31:16],
        on ? backplane_core_out[31:16] : 16'hffff);
      cmp_pin({backplane_driver_ctrl_out, local_driver_ctrl_out},
        on ? {backplane_core_ctrl, local_core_ctrl} : 6'h00);
    end
    $display("test standby done");
    for (int s = 0; s < 8; s++) begin
      wr(15'h0000, 16'(s));
      @(posedge ref_clk);
      mem_addr <= $random(seed); mem_wdata <= $random(seed); mem_wr <= 1'b1;
      #1 cmp_pin({lcm_wr, bcm_wr, sel_wdata}, {s == 0, s == 1, mem_wdata});
      @(posedge ref_clk);
      mem_wr <= 1'b0; mem_rd <= 1'b1;
      #1 cmp_pin({lcm_rd, bcm_rd, ldm_rd, bdm_rd}, s < 4 ? 4'h8 >> s : 4'h0);
      @(posedge ref_clk);
      mem_rd <= 1'b0;
      #1 cmp_pin(mem_rdata, s < 4 ? 16'(mem_addr) ^ (16'(s) << 13) : 16'h0000);
    end
    $display("test memory_select done");
    block_program_go <= 1'b1;
    wr(15'h0000, 16'h0010); cmp_pin(block_program_enable, 1'b1);
    wr(15'h0000, 16'h0000); cmp_pin(block_program_abort, 1'b1);
    @(posedge ref_clk);
    #1 cmp_pin({block_program_abort, block_program_enable}, 2'h0);
    $display("test abort done");
    tally_and_finish;
  end
endmodule : tb_top
